// File: mb_rtu_pkg.sv
// Constants, field values and state codes shared by the slave frame engine.
// Assumes a 25 MHz core clock and an 11-bit character on the serial line.
package mb_rtu_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned BAUD = 9600;
  localparam int unsigned BITS_PER_CHAR = 11;
  // Idle gap in tenths of a character time
  localparam int unsigned GAP_CHARS_X10 = 35;
  // Rounded up and one past, so the gap is strictly longer than 3.5 characters of 2604-cycle bits
  localparam int unsigned GAP_CYCLES = ((CLK_HZ / BAUD) * BITS_PER_CHAR * GAP_CHARS_X10 + 9) / 10 + 1;

  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [7:0] MIN_STATION = 8'h01;
  localparam logic [7:0] MAX_STATION = 8'hF7;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h06;
  localparam logic [7:0] ERR_FLAG = 8'h80;
  localparam logic [7:0] ERR_CMD = 8'h01;
  localparam logic [7:0] ERR_ADDR = 8'h02;
  localparam logic [7:0] ERR_DATA = 8'h03;
  localparam logic [7:0] ERR_PROC = 8'h04;
  localparam logic [7:0] RSP_OK = 8'h00;
  localparam logic [4:0] MAX_WORDS = 5'h0C;
  localparam logic [7:0] REQ_LEN = 8'h08;
  localparam logic [7:0] MIN_LEN = 8'h04;
  localparam logic [7:0] LAST_LOW = 8'hFF;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [4:0] ERR_BODY = 5'h03;
  localparam logic [4:0] WRITE_BODY = 5'h06;
  localparam logic [4:0] READ_HDR = 5'h03;

  typedef enum logic [2:0] {
    ST_RX = 3'h0,
    ST_CHECK = 3'h1,
    ST_ACCESS = 3'h3,
    ST_WAIT = 3'h2,
    ST_SEND = 3'h6,
    ST_DRAIN = 3'h7,
    ST_GAP = 3'h5
  } state_e;
endpackage

// File: crc_if.sv
// Carrier between the frame engine and its CRC16 units.
// Assumes both ends sit in the core clock domain.
`timescale 1ns/1ps
`default_nettype none
interface crc_if;
  logic clr;
  logic en;
  logic [7:0] data;
  logic [15:0] crc;
  modport unit (input clr, input en, input data, output crc);
  modport user (output clr, output en, output data, input crc);
endinterface
`default_nettype wire

// File: crc16_unit.sv
// Byte-wide CRC16 accumulator, one byte per enabled cycle.
// Assumes the user raises clr before or with a frame's first byte.
`timescale 1ns/1ps
`default_nettype none
module crc16_unit (
  input wire logic core_clk_i,
  input wire logic srst_i,
  crc_if.unit c
);
  logic [15:0] crc_q;

  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] x;
    x = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ mb_rtu_pkg::CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      crc_q <= mb_rtu_pkg::CRC_PRESET;
    end else if (c.en) begin
      crc_q <= crc_step(c.clr ? mb_rtu_pkg::CRC_PRESET : crc_q, c.data);
    end else if (c.clr) begin
      crc_q <= mb_rtu_pkg::CRC_PRESET;
    end
  end

  assign c.crc = crc_q;
endmodule
`default_nettype wire

// File: modbus_rtu_slave_framer.sv
// Modbus-RTU slave frame engine: gap framing, address filter, read/write decode, replies.
// Assumes a byte UART on both sides and a parameter store that answers each word request.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Station address 1 to 247 is ours; address 0 is broadcast.
// - A line idle over 3.5 characters starts a new frame.
// - Every sent frame has over 3.5 idle characters before and after.
// - Only one station drives the half-duplex line; others listen.
// - Only word access: 0x03 reads, 0x06 writes one parameter.
// - Read up to 12 words, never past the group's last parameter.
// - Frame error or failed access on a frame to our own station gets an error reply, unless the frame is under 4 bytes or is cut before its check field.
// - Error codes: 01 command, 02 address, 03 data, 04 not processable.
// - Parameter address travels high byte first.
// - Read carries a 16-bit count, high first; write changes one word.
// - Data words travel high byte first.
// - Normal reply: station, action echo, data, check field.
// - Frames end with CRC16, low byte then high byte.
// - CRC starts at 0xFFFF and covers only the eight data bits.
// - Per byte XOR, then eight right shifts with 0xA001 feedback.
// - Received CRC is recomputed; mismatch is a transmission error.
// - Broadcast frames are acted on but never answered.
module modbus_rtu_slave_framer #(
  parameter int unsigned GAP_CYCLES = mb_rtu_pkg::GAP_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] station_addr_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_err_i,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic tx_busy_i,
  output logic drv_en_o,
  output logic req_valid_o,
  output logic req_write_o,
  output logic [15:0] req_addr_o,
  output logic [15:0] req_wdata_o,
  input wire logic rsp_valid_i,
  input wire logic [7:0] rsp_code_i,
  input wire logic [15:0] rsp_data_i,
  output logic crc_err_o
);
  mb_rtu_pkg::state_e state_q;
  logic [31:0] idle_q;
  logic gap;
  logic [7:0] cnt_q;
  logic bad_q;
  logic [7:0] rxb_q [0:7];
  logic [15:0] word_q [0:11];
  logic [3:0] n_q;
  logic [3:0] widx_q;
  logic is_err_q;
  logic bcast_q;
  logic [7:0] code_q;
  logic [4:0] txi_q;
  logic settle_q;
  logic rx_start;
  logic rx_add;
  logic tx_acc;
  logic [4:0] body_len;
  logic [7:0] next_byte;
  logic ours;
  logic bcast;
  logic [15:0] count;
  logic [8:0] last_low;
  logic [15:0] base;
  logic cut;

  crc_if rx_crc ();
  crc_if tx_crc ();

  crc16_unit u_rx_crc (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .c(rx_crc)
  );

  crc16_unit u_tx_crc (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .c(tx_crc)
  );

  assign gap = (idle_q >= GAP_CYCLES);
  assign rx_start = (state_q == mb_rtu_pkg::ST_RX) && rx_valid_i && gap;
  assign rx_add = (state_q == mb_rtu_pkg::ST_RX) && rx_valid_i && !gap && (cnt_q != 8'h00);
  assign tx_acc = tx_valid_o && tx_ready_i;
  assign base = {rxb_q[2], rxb_q[3]};
  assign count = {rxb_q[4], rxb_q[5]};
  assign last_low = {1'b0, rxb_q[3]} + {1'b0, count[7:0]} - 9'h001;
  assign ours = (station_addr_i >= mb_rtu_pkg::MIN_STATION) && (station_addr_i <= mb_rtu_pkg::MAX_STATION)
                && (rxb_q[0] == station_addr_i);
  assign bcast = (rxb_q[0] == mb_rtu_pkg::BCAST_ADDR);
  // A known command shorter than a full request lost its check field to a gap
  assign cut = ((rxb_q[1] == mb_rtu_pkg::CMD_READ) || (rxb_q[1] == mb_rtu_pkg::CMD_WRITE))
               && (cnt_q < mb_rtu_pkg::REQ_LEN);

  // Receive sum restarts on a frame's first byte; a mismatch leaves it non-zero
  always_comb begin
    rx_crc.clr = rx_start;
    rx_crc.en = rx_start || rx_add;
    rx_crc.data = rx_data_i;
    tx_crc.clr = (state_q != mb_rtu_pkg::ST_SEND);
    tx_crc.en = (state_q == mb_rtu_pkg::ST_SEND) && tx_acc && (txi_q < body_len);
    tx_crc.data = tx_data_o;
  end

  always_comb begin
    if (is_err_q) begin
      body_len = mb_rtu_pkg::ERR_BODY;
    end else if (rxb_q[1] == mb_rtu_pkg::CMD_READ) begin
      body_len = mb_rtu_pkg::READ_HDR + {n_q, 1'b0};
    end else begin
      body_len = mb_rtu_pkg::WRITE_BODY;
    end
  end

  // Reply layout follows the request: station, action, data, check field
  always_comb begin
    next_byte = 8'h00;
    if (txi_q == body_len) begin
      next_byte = tx_crc.crc[7:0];
    end else if (txi_q > body_len) begin
      next_byte = tx_crc.crc[15:8];
    end else if (txi_q == 5'h00) begin
      next_byte = rxb_q[0];
    end else if (txi_q == 5'h01) begin
      next_byte = is_err_q ? (rxb_q[1] | mb_rtu_pkg::ERR_FLAG) : rxb_q[1];
    end else if (is_err_q) begin
      next_byte = code_q;
    end else if (rxb_q[1] == mb_rtu_pkg::CMD_WRITE) begin
      next_byte = rxb_q[txi_q[2:0]];
    end else if (txi_q == 5'h02) begin
      next_byte = {3'h0, n_q, 1'b0};
    end else begin
      next_byte = txi_q[0] ? word_q[4'((txi_q - 5'h03) >> 1)][15:8]
                           : word_q[4'((txi_q - 5'h03) >> 1)][7:0];
    end
  end

  // Any activity on the line, ours included, restarts the idle measure
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      idle_q <= 32'h0000_0000;
    end else if (rx_valid_i || drv_en_o) begin
      idle_q <= 32'h0000_0000;
    end else if (!gap) begin
      idle_q <= idle_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cnt_q <= 8'h00;
      bad_q <= 1'b0;
    end else if (rx_start) begin
      cnt_q <= 8'h01;
      bad_q <= rx_err_i;
    end else if (rx_add) begin
      cnt_q <= (cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01;
      bad_q <= bad_q | rx_err_i;
    end else if (state_q == mb_rtu_pkg::ST_CHECK) begin
      cnt_q <= 8'h00;
    end
  end

  // Only the first eight bytes are kept; longer frames are rejected by length
  always_ff @(posedge core_clk_i) begin
    if (rx_start) begin
      rxb_q[0] <= rx_data_i;
    end else if (rx_add && (cnt_q < mb_rtu_pkg::REQ_LEN)) begin
      rxb_q[cnt_q[2:0]] <= rx_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if ((state_q == mb_rtu_pkg::ST_WAIT) && rsp_valid_i) begin
      word_q[widx_q] <= rsp_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_q <= mb_rtu_pkg::ST_RX;
      is_err_q <= 1'b0;
      bcast_q <= 1'b0;
      code_q <= mb_rtu_pkg::RSP_OK;
      n_q <= 4'h0;
      widx_q <= 4'h0;
      crc_err_o <= 1'b0;
    end else begin
      crc_err_o <= 1'b0;
      unique case (state_q)
        mb_rtu_pkg::ST_RX: begin
          if (gap && (cnt_q != 8'h00)) begin
            state_q <= mb_rtu_pkg::ST_CHECK;
          end
        end
        mb_rtu_pkg::ST_CHECK: begin
          is_err_q <= 1'b0;
          bcast_q <= bcast;
          widx_q <= 4'h0;
          n_q <= (rxb_q[1] == mb_rtu_pkg::CMD_READ) ? count[3:0] : 4'h1;
          if (!(ours || bcast) || (cnt_q < mb_rtu_pkg::MIN_LEN) || cut) begin
            state_q <= mb_rtu_pkg::ST_RX;
          end else if (bad_q || (rx_crc.crc != 16'h0000)) begin
            crc_err_o <= 1'b1;
            is_err_q <= 1'b1;
            code_q <= mb_rtu_pkg::ERR_PROC;
            state_q <= bcast ? mb_rtu_pkg::ST_RX : mb_rtu_pkg::ST_SEND;
          end else if ((rxb_q[1] != mb_rtu_pkg::CMD_READ) && (rxb_q[1] != mb_rtu_pkg::CMD_WRITE)) begin
            is_err_q <= 1'b1;
            code_q <= mb_rtu_pkg::ERR_CMD;
            state_q <= bcast ? mb_rtu_pkg::ST_RX : mb_rtu_pkg::ST_SEND;
          end else if (cnt_q != mb_rtu_pkg::REQ_LEN) begin
            is_err_q <= 1'b1;
            code_q <= mb_rtu_pkg::ERR_DATA;
            state_q <= bcast ? mb_rtu_pkg::ST_RX : mb_rtu_pkg::ST_SEND;
          end else if ((rxb_q[1] == mb_rtu_pkg::CMD_READ)
                       && ((count == 16'h0000) || (count > {11'h000, mb_rtu_pkg::MAX_WORDS}))) begin
            is_err_q <= 1'b1;
            code_q <= mb_rtu_pkg::ERR_DATA;
            state_q <= bcast ? mb_rtu_pkg::ST_RX : mb_rtu_pkg::ST_SEND;
          end else if ((rxb_q[1] == mb_rtu_pkg::CMD_READ) && (last_low > {1'b0, mb_rtu_pkg::LAST_LOW})) begin
            is_err_q <= 1'b1;
            code_q <= mb_rtu_pkg::ERR_ADDR;
            state_q <= bcast ? mb_rtu_pkg::ST_RX : mb_rtu_pkg::ST_SEND;
          end else begin
            state_q <= mb_rtu_pkg::ST_ACCESS;
          end
        end
        mb_rtu_pkg::ST_ACCESS: begin
          state_q <= mb_rtu_pkg::ST_WAIT;
        end
        mb_rtu_pkg::ST_WAIT: begin
          if (rsp_valid_i) begin
            if (rsp_code_i != mb_rtu_pkg::RSP_OK) begin
              is_err_q <= 1'b1;
              code_q <= rsp_code_i;
              state_q <= bcast_q ? mb_rtu_pkg::ST_RX : mb_rtu_pkg::ST_SEND;
            end else if (widx_q + 4'h1 == n_q) begin
              state_q <= bcast_q ? mb_rtu_pkg::ST_RX : mb_rtu_pkg::ST_SEND;
            end else begin
              widx_q <= widx_q + 4'h1;
              state_q <= mb_rtu_pkg::ST_ACCESS;
            end
          end
        end
        mb_rtu_pkg::ST_SEND: begin
          if (tx_acc && (txi_q == body_len + 5'h01)) begin
            state_q <= mb_rtu_pkg::ST_DRAIN;
          end
        end
        mb_rtu_pkg::ST_DRAIN: begin
          if (settle_q && !tx_busy_i) begin
            state_q <= mb_rtu_pkg::ST_GAP;
          end
        end
        mb_rtu_pkg::ST_GAP: begin
          if (gap) begin
            state_q <= mb_rtu_pkg::ST_RX;
          end
        end
        default: begin
          state_q <= mb_rtu_pkg::ST_RX;
        end
      endcase
    end
  end

  // Reply starts only after a detected gap, so the leading idle is already met
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
      txi_q <= 5'h00;
    end else if (state_q != mb_rtu_pkg::ST_SEND) begin
      tx_valid_o <= 1'b0;
      txi_q <= 5'h00;
    end else if (tx_acc) begin
      tx_valid_o <= 1'b0;
      txi_q <= txi_q + 5'h01;
    end else if (!tx_valid_o) begin
      tx_valid_o <= 1'b1;
      tx_data_o <= next_byte;
    end
  end

  // The UART may raise busy a cycle late, hence one settle cycle
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      settle_q <= 1'b0;
      drv_en_o <= 1'b0;
    end else begin
      settle_q <= (state_q == mb_rtu_pkg::ST_DRAIN);
      drv_en_o <= (state_q == mb_rtu_pkg::ST_SEND)
                  || ((state_q == mb_rtu_pkg::ST_DRAIN) && !(settle_q && !tx_busy_i));
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      req_valid_o <= 1'b0;
      req_write_o <= 1'b0;
      req_addr_o <= 16'h0000;
      req_wdata_o <= 16'h0000;
    end else begin
      req_valid_o <= (state_q == mb_rtu_pkg::ST_ACCESS);
      if (state_q == mb_rtu_pkg::ST_ACCESS) begin
        req_write_o <= (rxb_q[1] == mb_rtu_pkg::CMD_WRITE);
        req_addr_o <= base + {12'h000, widx_q};
        req_wdata_o <= count;
      end
    end
  end
endmodule
`default_nettype wire

// File: modbus_rtu_slave_framer_chk.sv
// Timing checks on the frame engine's ports.
// Assumes one core clock and the design's synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module modbus_rtu_slave_framer_chk #(
  parameter int unsigned GAP_CYCLES = 50
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic rx_valid_i,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic tx_busy_i,
  input wire logic drv_en_o,
  input wire logic req_valid_o,
  input wire logic req_write_o,
  input wire logic [15:0] req_addr_o,
  input wire logic crc_err_o
);
  // Idle since last received byte; saturates so it cannot wrap
  logic [31:0] idle_q;
  always_ff @(posedge core_clk_i) begin
    if (srst_i || rx_valid_i) begin
      idle_q <= 32'h0;
    end else if (idle_q < GAP_CYCLES + 2) begin
      idle_q <= idle_q + 32'h1;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  a_byte_held: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("tx byte dropped before accept");
  a_pause_after_accept: assert property (tx_valid_o && tx_ready_i |=> !tx_valid_o)
    else $error("no pause after byte accept");
  a_drive_covers_tx: assert property (tx_valid_o |-> drv_en_o)
    else $error("byte offered without line driver");
  a_gap_before_send: assert property ($rose(drv_en_o) |-> idle_q >= GAP_CYCLES)
    else $error("reply started without idle gap");
  a_quiet_after_send: assert property ($fell(drv_en_o) |=> !drv_en_o [*8])
    else $error("line taken again too soon");
  a_drain_waits_busy: assert property ($fell(drv_en_o) |-> !$past(tx_busy_i))
    else $error("driver released while shifter busy");
  a_req_one_pulse: assert property (req_valid_o |=> !req_valid_o)
    else $error("store request longer than one cycle");
  a_req_addr_hold: assert property (!req_valid_o |-> $stable(req_addr_o))
    else $error("store address moved between requests");
  a_crc_err_pulse: assert property (crc_err_o |=> !crc_err_o)
    else $error("check error flag longer than one cycle");
  c_reply_done: cover property ($fell(drv_en_o));
  c_crc_error: cover property (crc_err_o);
  c_write_req: cover property (req_valid_o && req_write_o);
endmodule
bind modbus_rtu_slave_framer modbus_rtu_slave_framer_chk #(.GAP_CYCLES(GAP_CYCLES)) chk_i (.*);
`default_nettype wire

// File: host_side_model.sv
// Far-side model: byte UART that stalls and stays busy, and a slow parameter store.
// Assumes the core clock; the bench reads the sent queue directly.
`timescale 1ns/1ps
`default_nettype none
module host_side_model (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic tx_busy_o,
  input wire logic req_valid_i,
  input wire logic [15:0] req_addr_i,
  input wire logic [15:0] err_addr_i,
  output logic rsp_valid_o,
  output logic [7:0] rsp_code_o,
  output logic [15:0] rsp_data_o
);
  logic [7:0] sent[$];
  logic [1:0] wait_q;
  logic [3:0] busy_q;
  logic [1:0] lat_q;
  logic pend_q;
  logic [15:0] addr_q;
  assign tx_busy_o = busy_q != 4'h0;
  // Ready held back three cycles so the engine must hold its byte
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      tx_ready_o <= 1'b0;
      wait_q <= 2'h0;
      busy_q <= 4'h0;
    end else begin
      tx_ready_o <= 1'b0;
      if (tx_valid_i && !tx_ready_o) begin
        wait_q <= wait_q + 2'h1;
        tx_ready_o <= wait_q == 2'h2;
      end
      if (tx_valid_i && tx_ready_o) begin
        sent.push_back(tx_data_i);
        wait_q <= 2'h0;
        busy_q <= 4'h6;
      end else if (busy_q != 4'h0) begin
        busy_q <= busy_q - 4'h1;
      end
    end
  end
  // Store answers late; stale answer lines toggle so nothing stale looks valid
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      pend_q <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_code_o <= 8'h00;
      rsp_data_o <= 16'h0000;
    end else begin
      rsp_valid_o <= 1'b0;
      rsp_code_o <= ~rsp_code_o;
      rsp_data_o <= ~rsp_data_o;
      if (req_valid_i) begin
        pend_q <= 1'b1;
        lat_q <= 2'h2;
        addr_q <= req_addr_i;
      end else if (pend_q && lat_q != 2'h0) begin
        lat_q <= lat_q - 2'h1;
      end else if (pend_q) begin
        pend_q <= 1'b0;
        rsp_valid_o <= 1'b1;
        rsp_data_o <= addr_q ^ 16'hA5A5;
        rsp_code_o <= (addr_q == err_addr_i) ? 8'h04 : 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

// File: modbus_rtu_slave_framer_test.sv
// Self-checking bench: request table, then check-field error, cut-off frame, reset.
// Assumes the host side model and a shortened idle gap.
`timescale 1ns/1ps
`default_nettype none
module modbus_rtu_slave_framer_test;
  localparam int GAP = 50;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic rx_v = 1'b0;
  logic [7:0] rx_d = 8'h00;
  logic rx_e = 1'b0;
  logic [7:0] stn = 8'h11;
  logic [15:0] cv;
  logic [7:0] tx_d, rsp_code;
  logic tx_v, tx_rdy, tx_busy, drv_en, req_v, req_w, rsp_v, crc_err;
  logic [15:0] req_addr, req_wdata, rsp_data;
  int num_errors = 0;
  int samples_checked = 0;
  int crc_cnt = 0;
  int n;
  // Station, command, four body bytes, expected code (FF = silence)
  logic [55:0] rows [10] = '{56'h11_03_10_00_00_01_00, 56'h11_03_10_F4_00_0C_00,
    56'h11_03_10_F5_00_0C_02, 56'h11_03_10_00_00_0D_03, 56'h11_03_10_00_00_00_03,
    56'h11_06_20_00_00_07_00, 56'h11_04_10_00_00_01_01, 56'h22_03_10_00_00_01_FF,
    56'h11_03_30_00_00_01_04, 56'h00_06_20_01_02_03_FF};
  initial forever #20 clk = ~clk;
  always @(negedge clk) if (crc_err === 1'b1) crc_cnt++;
  modbus_rtu_slave_framer #(.GAP_CYCLES(GAP)) DUT (.core_clk_i(clk), .srst_i(srst),
    .station_addr_i(stn), .rx_valid_i(rx_v), .rx_data_i(rx_d), .rx_err_i(rx_e),
    .tx_data_o(tx_d), .tx_valid_o(tx_v), .tx_ready_i(tx_rdy), .tx_busy_i(tx_busy),
    .drv_en_o(drv_en), .req_valid_o(req_v), .req_write_o(req_w), .req_addr_o(req_addr),
    .req_wdata_o(req_wdata), .rsp_valid_i(rsp_v), .rsp_code_i(rsp_code),
    .rsp_data_i(rsp_data), .crc_err_o(crc_err));
  host_side_model m (.core_clk_i(clk), .srst_i(srst), .tx_data_i(tx_d), .tx_valid_i(tx_v),
    .tx_ready_o(tx_rdy), .tx_busy_o(tx_busy), .req_valid_i(req_v), .req_addr_i(req_addr),
    .err_addr_i(16'h3000), .rsp_valid_o(rsp_v), .rsp_code_o(rsp_code), .rsp_data_o(rsp_data));
  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  // Gap first, then one byte every other cycle
  task automatic send(input logic [7:0] q[$]);
    m.sent.delete();
    repeat (GAP + 5) @(negedge clk);
    foreach (q[i]) begin
      rx_v = 1'b1;
      rx_d = q[i];
      @(negedge clk);
      rx_v = 1'b0;
      @(negedge clk);
    end
  endtask
  task automatic xact(input logic [55:0] r, input bit bad);
    logic [7:0] q[$];
    logic [7:0] e[$];
    logic [15:0] c;
    int i;
    q = {r[55:48], r[47:40], r[39:32], r[31:24], r[23:16], r[15:8]};
    c = crc16(q) ^ {15'h0000, bad};
    send({q, c[7:0], c[15:8]});
    if (r[7:0] == 8'h00 && q[1] == 8'h03) begin
      e = {q[0], q[1], q[5] << 1};
      for (i = 0; i < q[5]; i++) begin
        c = ({q[2], q[3]} + 16'(i)) ^ 16'hA5A5;
        e = {e, c[15:8], c[7:0]};
      end
    end else if (r[7:0] == 8'h00) e = q;
    else if (r[7:0] != 8'hFF) e = {q[0], q[1] | 8'h80, r[7:0]};
    if (e.size() > 0) begin
      c = crc16(e);
      e = {e, c[7:0], c[15:8]};
    end
    for (i = 0; i < 4000; i++) begin
      @(negedge clk);
      if (e.size() == m.sent.size() && drv_en === 1'b0 && i > 300) break;
    end
    if (i == 4000) begin
      $display("BAD reply wait expected done seen timeout");
      num_errors++;
      end_of_test();
    end
    chk("reply length", 16'(e.size()), 16'(m.sent.size()));
    foreach (e[k]) if (k < m.sent.size()) chk("reply byte", {8'h00, e[k]}, {8'h00, m.sent[k]});
  endtask
  initial begin
    repeat (12) @(negedge clk);
    chk("drv_en in reset", 16'h0000, {15'h0000, drv_en});
    srst = 1'b0;
    foreach (rows[k]) xact(rows[k], 1'b0);
    chk("write address", 16'h2001, req_addr);
    chk("write data", 16'h0203, req_wdata);
    chk("write flag", 16'h0001, {15'h0000, req_w});
    n = crc_cnt;
    xact(56'h11_03_10_00_00_01_04, 1'b1);
    chk("crc error pulses", 16'(n + 1), 16'(crc_cnt));
    // Short frame must vanish, not merge with the next one
    send({8'h11, 8'h03, 8'h10});
    xact(rows[0], 1'b0);
    // Read cut before its check field: no reply and no error pulse
    n = crc_cnt;
    send({8'h11, 8'h03, 8'h10, 8'h00, 8'h00, 8'h01});
    repeat (300) @(negedge clk);
    chk("cut frame reply", 16'h0000, 16'(m.sent.size()));
    chk("cut frame error", 16'(n), 16'(crc_cnt));
    // Character error on every byte of an addressed read
    rx_e = 1'b1;
    xact(56'h11_03_10_00_00_01_04, 1'b0);
    rx_e = 1'b0;
    chk("byte error pulses", 16'(n + 1), 16'(crc_cnt));
    // Out-of-range own address matches nothing but broadcast
    stn = 8'hF8;
    xact(56'hF8_03_10_00_00_01_FF, 1'b0);
    stn = 8'h11;
    // Reset in the middle of a reply must release the line at once
    cv = crc16({8'h11, 8'h03, 8'h10, 8'h00, 8'h00, 8'h01});
    send({8'h11, 8'h03, 8'h10, 8'h00, 8'h00, 8'h01, cv[7:0], cv[15:8]});
    for (n = 0; n < 400 && drv_en !== 1'b1; n++) @(negedge clk);
    chk("reply started", 16'h0001, {15'h0000, drv_en});
    if (n == 400) end_of_test();
    srst = 1'b1;
    repeat (2) @(negedge clk);
    chk("tx_valid in reset", 16'h0000, {15'h0000, tx_v});
    chk("drv_en mid reset", 16'h0000, {15'h0000, drv_en});
    chk("req_valid in reset", 16'h0000, {15'h0000, req_v});
    srst = 1'b0;
    xact(rows[0], 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
